/* verilog/decode_defs.vh */
// constants for the instruction decode and cycle-timing block
// assumes: included by bare name from the decoder files
`ifndef DECODE_DEFS_VH
`define DECODE_DEFS_VH

`define INSN_W          14
`define FADDR_W         7
`define FADDR_LSB       0
`define DEST_BIT        7
`define TOP_MSB         13
`define TOP_LSB         12
`define NIB_MSB         11
`define NIB_LSB         8
`define BIT_LSB         7
`define LIT_MSB         7
`define PTR_SEL_BIT     2
`define Q_PER_CYCLE     2'h3
`define INDIRECT_HI     7'h01
`define INDIRECT_LO     7'h00
`define PTR_PROG_BIT    15

`define TOP_BYTE        2'h0
`define TOP_BIT         2'h1
`define TOP_JUMP        2'h2
`define TOP_LIT         2'h3

`define NIB_ADD         4'h7
`define NIB_AND         4'h5
`define NIB_OR          4'h4
`define NIB_RLC         4'hd
`define NIB_RRC         4'hc
`define NIB_DECSZ       4'hb
`define NIB_INCSZ       4'hf
`define NIB_ADDC        4'hd
`define NIB_ASR         4'h7
`define NIB_LSL         4'h5
`define NIB_LSR         4'h6
`define NIB_BTC         2'h2
`define NIB_BTS         2'h3

`define OP_NOP          4'h0
`define OP_ADD          4'h1
`define OP_ADDC         4'h2
`define OP_AND          4'h3
`define OP_OR           4'h4
`define OP_ASR          4'h5
`define OP_LSL          4'h6
`define OP_LSR          4'h7
`define OP_RLC          4'h8
`define OP_RRC          4'h9
`define OP_DECSZ        4'ha
`define OP_INCSZ        4'hb
`define OP_BTC          4'hc
`define OP_BTS          4'hd

`define FMT_BYTE        2'h0
`define FMT_BIT         2'h1
`define FMT_LIT         2'h2

`define INH_CALL_VIA_WORK       14'h000a
`define INH_RETURN      14'h0008
`define INH_RETURN_FROM_INTERRUPT      14'h0009
`define INH_BRW         14'h000b
`define NIB_RETURN_WITH_LITERAL       4'h4
`define BRA_HI          3'h1

`endif

/* verilog/flag_alu.v */
// flag-producing datapath for the byte-oriented file operations
// assumes: operands are stable for the cycle in which the result is taken
`include "decode_defs.vh"
`timescale 1ns/1ps

module flag_alu (
    input  wire [3:0] op,
    input  wire [7:0] fval,
    input  wire [7:0] wval,
    input  wire       cin,
    output reg  [7:0] res,
    output reg        c_out,
    output reg        dc_out,
    output reg        z_out,
    output reg        c_we,
    output reg        dc_we,
    output reg        z_we
);

    reg [8:0] sum;
    reg [4:0] nsum;

    // one combinational pass; each op enables only the flags it touches
    always @* begin
        sum    = 9'h000;
        nsum   = 5'h00;
        res    = fval;
        c_out  = cin;
        dc_out = 1'b0;
        c_we   = 1'b0;
        dc_we  = 1'b0;
        z_we   = 1'b0;
        case (op)
            `OP_ADD, `OP_ADDC: begin
                sum  = {1'b0, fval} + {1'b0, wval}
                     + {8'h00, (op == `OP_ADDC) & cin};
                nsum = {1'b0, fval[3:0]} + {1'b0, wval[3:0]}
                     + {4'h0, (op == `OP_ADDC) & cin};
                res    = sum[7:0];
                c_out  = sum[8];
                dc_out = nsum[4];
                c_we   = 1'b1;
                dc_we  = 1'b1;
                z_we   = 1'b1;
            end
            `OP_AND: begin
                res  = fval & wval;
                z_we = 1'b1;
            end
            `OP_OR: begin
                res  = fval | wval;
                z_we = 1'b1;
            end
            `OP_ASR: begin
                res   = {fval[7], fval[7:1]};
                c_out = fval[0];
                c_we  = 1'b1;
                z_we  = 1'b1;
            end
            `OP_LSL: begin
                res   = {fval[6:0], 1'b0};
                c_out = fval[7];
                c_we  = 1'b1;
                z_we  = 1'b1;
            end
            `OP_LSR: begin
                res   = {1'b0, fval[7:1]};
                c_out = fval[0];
                c_we  = 1'b1;
                z_we  = 1'b1;
            end
            `OP_RLC: begin
                res   = {fval[6:0], cin};
                c_out = fval[7];
                c_we  = 1'b1;
            end
            `OP_RRC: begin
                res   = {cin, fval[7:1]};
                c_out = fval[0];
                c_we  = 1'b1;
            end
            `OP_DECSZ: res = fval - 8'h01;
            `OP_INCSZ: res = fval + 8'h01;
            default:   res = fval;
        endcase
        z_out = (res == 8'h00);
    end

endmodule

/* verilog/insn_decode_timing.v */
// instruction decode, read-modify-write sequencing and cycle timing
// assumes: file registers answer a read in the same oscillator clock
// assumes: insn is held by program memory while fetch_req is low
`include "decode_defs.vh"
`timescale 1ns/1ps

module insn_decode_timing (
    input  wire                clk,
    input  wire                rst_n,
    input  wire [`INSN_W-1:0]  insn,
    input  wire [7:0]          file_rdata,
    input  wire [15:0]         ptr0,
    input  wire [15:0]         ptr1,
    output reg                 fetch_req,
    output reg  [1:0]          q_phase,
    output reg  [1:0]          fmt,
    output reg  [`FADDR_W-1:0] file_addr,
    output reg                 file_rd,
    output reg                 file_wr,
    output reg  [7:0]          file_wdata,
    output reg  [7:0]          work,
    output reg                 carry,
    output reg                 nibble_overflow_flag,
    output reg                 zero,
    output reg                 pc_change,
    output reg                 skip_taken,
    output reg                 nop_cycle,
    output reg                 ptr_sel,
    output reg  [2:0]          bit_sel
);

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    // opcode class from the two top bits and the next nibble
    function [3:0] decode_op;
        input [`INSN_W-1:0] w;
        reg   [1:0] top;
        reg   [3:0] nib;
        begin
            top = w[`TOP_MSB:`TOP_LSB];
            nib = w[`NIB_MSB:`NIB_LSB];
            decode_op = `OP_NOP;
            if (top == `TOP_BYTE) begin
                case (nib)
                    `NIB_ADD:   decode_op = `OP_ADD;
                    `NIB_AND:   decode_op = `OP_AND;
                    `NIB_OR:    decode_op = `OP_OR;
                    `NIB_RLC:   decode_op = `OP_RLC;
                    `NIB_RRC:   decode_op = `OP_RRC;
                    `NIB_DECSZ: decode_op = `OP_DECSZ;
                    `NIB_INCSZ: decode_op = `OP_INCSZ;
                    default:    decode_op = `OP_NOP;
                endcase
            end else if (top == `TOP_LIT) begin
                case (nib)
                    `NIB_ADDC:  decode_op = `OP_ADDC;
                    `NIB_ASR:   decode_op = `OP_ASR;
                    `NIB_LSL:   decode_op = `OP_LSL;
                    `NIB_LSR:   decode_op = `OP_LSR;
                    default:    decode_op = `OP_NOP;
                endcase
            end else if (top == `TOP_BIT) begin
                // only the two top nibble bits pick the op; rest is bit no.
                case (nib[3:2])
                    `NIB_BTC:   decode_op = `OP_BTC;
                    `NIB_BTS:   decode_op = `OP_BTS;
                    default:    decode_op = `OP_NOP;
                endcase
            end
        end
    endfunction

    // control-flow words that always take a second cycle
    function always_two;
        input [`INSN_W-1:0] w;
        begin
            always_two =
                (w[`TOP_MSB:`TOP_LSB] == `TOP_JUMP) ||
                (w == `INH_CALL_VIA_WORK) ||
                (w == `INH_RETURN) || (w == `INH_RETURN_FROM_INTERRUPT) ||
                ((w[`TOP_MSB:`TOP_LSB] == `TOP_LIT) &&
                 (w[`NIB_MSB:`NIB_LSB] == `NIB_RETURN_WITH_LITERAL)) ||
                (w == `INH_BRW) ||
                ((w[`TOP_MSB:`TOP_LSB] == `TOP_LIT) &&
                 (w[`NIB_MSB:`NIB_LSB+1] == `BRA_HI));
        end
    endfunction

    // format class of the word
    function [1:0] decode_fmt;
        input [`INSN_W-1:0] w;
        begin
            case (w[`TOP_MSB:`TOP_LSB])
                `TOP_BYTE: decode_fmt = `FMT_BYTE;
                `TOP_BIT:  decode_fmt = `FMT_BIT;
                // top 11 also holds byte ops: carry add and the shifts
                default:   decode_fmt = (decode_op(w) == `OP_NOP) ?
                                        `FMT_LIT : `FMT_BYTE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // sequencer states

    localparam [1:0] ST_EXEC  = 2'h0;  // normal single cycle
    localparam [1:0] ST_EXTRA = 2'h1;  // indirect-to-program stall
    localparam [1:0] ST_NOP   = 2'h2;  // flushed second cycle

    reg  [1:0]         state;
    reg  [1:0]         next_state;
    reg  [`INSN_W-1:0] ir;
    reg  [3:0]         op;
    reg  [3:0]         next_op;
    reg                need_nop;
    reg  [7:0]         fdata;

    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    wire       alu_z;
    wire       alu_c_we;
    wire       alu_dc_we;
    wire       alu_z_we;

    // datapath for the byte operations; fed with the file read
    flag_alu u_alu (
        .op     (op),
        .fval   (fdata),
        .wval   (work),
        .cin    (carry),
        .res    (alu_res),
        .c_out  (alu_c),
        .dc_out (alu_dc),
        .z_out  (alu_z),
        .c_we   (alu_c_we),
        .dc_we  (alu_dc_we),
        .z_we   (alu_z_we)
    );

    ////////////////////////////////////////////////////////////////////
    // combinational pieces of the current instruction

    wire [`FADDR_W-1:0] faddr   = ir[`FADDR_W-1:`FADDR_LSB];
    wire                dest_f  = ir[`DEST_BIT];
    wire [2:0]          bsel    = ir[`NIB_LSB+1:`BIT_LSB];
    wire                is_ind  = (faddr == `INDIRECT_LO) ||
                                  (faddr == `INDIRECT_HI);
    // the selected pointer decides whether the stall applies
    wire                psel    = faddr[0];
    wire                ptr_prog = psel ? ptr1[`PTR_PROG_BIT]
                                        : ptr0[`PTR_PROG_BIT];
    wire                bit_val = fdata[bsel];
    wire                has_file = (op != `OP_NOP);
    wire                skip_now =
        ((op == `OP_BTC) && !bit_val) ||
        ((op == `OP_BTS) &&  bit_val) ||
        (((op == `OP_DECSZ) || (op == `OP_INCSZ)) && alu_z);

    // next state: stall for indirect program access, then flush if needed
    always @* begin
        next_state = ST_EXEC;
        case (state)
            ST_EXEC: begin
                if (has_file && is_ind && ptr_prog)
                    next_state = ST_EXTRA;
                else if (need_nop || skip_now)
                    next_state = ST_NOP;
            end
            ST_EXTRA: begin
                if (need_nop || skip_now)
                    next_state = ST_NOP;
            end
            ST_NOP:  next_state = ST_EXEC;
            default: next_state = ST_EXEC;
        endcase
    end

    wire cycle_end = (q_phase == `Q_PER_CYCLE);
    // last cycle of this instruction: the next word is fetched after it
    wire done      = cycle_end && (next_state == ST_EXEC);
    // commit the read-modify-write at the last Q of the execute cycle, or of the stall cycle after it
    wire commit    = cycle_end && (next_state != ST_EXTRA) &&
                     (state != ST_NOP);

    always @* begin
        next_op = decode_op(insn);
    end

    ////////////////////////////////////////////////////////////////////
    // oscillator phase counter: four clocks per instruction cycle

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            q_phase <= 2'h0;
        else
            q_phase <= q_phase + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // instruction register and sequencer

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_NOP;
            ir        <= {`INSN_W{1'b0}};
            op        <= `OP_NOP;
            need_nop  <= 1'b0;
            fetch_req <= 1'b0;
            fmt       <= `FMT_BYTE;
            ptr_sel   <= 1'b0;
            bit_sel   <= 3'h0;
            nop_cycle <= 1'b1;
        end else begin
            fetch_req <= 1'b0;
            if (cycle_end) begin
                state     <= next_state;
                nop_cycle <= (next_state == ST_NOP);
            end
            if (done) begin
                // latch the whole word; every operand rides in it
                ir        <= insn;
                op        <= next_op;
                need_nop  <= always_two(insn);
                fmt       <= decode_fmt(insn);
                ptr_sel   <= insn[`PTR_SEL_BIT];
                bit_sel   <= insn[`NIB_LSB+1:`BIT_LSB];
                fetch_req <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file read, modify, write and flag update

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr            <= {`FADDR_W{1'b0}};
            fdata                <= 8'h00;
            file_rd              <= 1'b0;
            file_wr              <= 1'b0;
            file_wdata           <= 8'h00;
            work                 <= 8'h00;
            carry                <= 1'b0;
            nibble_overflow_flag <= 1'b0;
            zero                 <= 1'b0;
            pc_change            <= 1'b0;
            skip_taken           <= 1'b0;
        end else begin
            file_wr    <= 1'b0;
            pc_change  <= 1'b0;
            skip_taken <= 1'b0;
            // read is issued for every file op, the read-only bit tests included
            file_rd    <= has_file && (state == ST_EXEC) &&
                          (q_phase == 2'h0);
            file_addr  <= faddr;
            // keep the value seen under the strobe; the bus is only valid then
            if (file_rd)
                fdata  <= file_rdata;
            if (commit && has_file) begin
                if (op == `OP_BTC || op == `OP_BTS) begin
                    skip_taken <= skip_now;
                end else begin
                    if (dest_f) begin
                        file_wr    <= 1'b1;
                        file_wdata <= alu_res;
                    end else begin
                        work       <= alu_res;
                    end
                    if (alu_c_we)
                        carry <= alu_c;
                    if (alu_dc_we)
                        nibble_overflow_flag <= alu_dc;
                    if (alu_z_we)
                        zero <= alu_z;
                    skip_taken <= skip_now;
                end
            end
            if (commit && need_nop)
                pc_change <= 1'b1;
        end
    end

endmodule

/* dv/decode_checker_assertions.sv */
// concurrent checks on the decode and cycle-timing block's ports
// assumes: bound onto insn_decode_timing, one clock, async low reset
`timescale 1ns/1ps

module decode_checker (
    input wire        clk,
    input wire        rst_n,
    input wire [13:0] insn,
    input wire [7:0]  file_rdata,
    input wire [15:0] ptr0,
    input wire [15:0] ptr1,
    input wire        fetch_req,
    input wire [1:0]  q_phase,
    input wire [1:0]  fmt,
    input wire [6:0]  file_addr,
    input wire        file_rd,
    input wire        file_wr,
    input wire [7:0]  file_wdata,
    input wire [7:0]  work,
    input wire        carry,
    input wire        nibble_overflow_flag,
    input wire        zero,
    input wire        pc_change,
    input wire        skip_taken,
    input wire        nop_cycle,
    input wire        ptr_sel,
    input wire [2:0]  bit_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    reg [13:0] prev_insn;
    reg [3:0]  since_rd;

    ////////////////////////////////////////////////////////////////////////
    // word seen at the latch edge, and age of the last read strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_insn <= 14'h0000;
            since_rd <= 4'hf;
        end else begin
            prev_insn <= insn;
            if (file_rd)
                since_rd <= 4'h0;
            else if (since_rd != 4'hf)
                since_rd <= since_rd + 4'h1; // saturates, never wraps
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_phases;
        q_phase == 2'h1 ##1 q_phase == 2'h2 ##1 q_phase == 2'h3
            ##1 q_phase == 2'h0;
    endsequence
    sequence s_quiet;
        !fetch_req [*3];
    endsequence

    property p_cycle_four;
        q_phase == 2'h0 |=> s_phases;
    endproperty
    a_cycle_four: assert property (p_cycle_four)
        else $error("instruction cycle is not four clocks");
    property p_fetch_phase;
        fetch_req |-> q_phase == 2'h0;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase)
        else $error("fetch outside the first phase");
    property p_fetch_space;
        fetch_req |=> s_quiet;
    endproperty
    a_fetch_space: assert property (p_fetch_space)
        else $error("fetches closer than one instruction cycle");
    property p_rd_phase;
        file_rd |-> q_phase == 2'h1;
    endproperty
    a_rd_phase: assert property (p_rd_phase)
        else $error("file read outside its phase");
    property p_rmw;
        file_wr |-> since_rd <= 4'hb;
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("file write without a preceding read");
    property p_nop_quiet;
        nop_cycle |-> !file_rd;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("file read during a flushed cycle");
    property p_skip_nop;
        skip_taken |-> ##[0:4] nop_cycle;
    endproperty
    a_skip_nop: assert property (p_skip_nop)
        else $error("taken skip without a flushed cycle");
    property p_pc_nop;
        pc_change |-> ##[0:4] nop_cycle;
    endproperty
    a_pc_nop: assert property (p_pc_nop)
        else $error("control transfer without a flushed cycle");
    property p_bit_fields;
        fetch_req && prev_insn[13:12] == 2'h1 |-> fmt == 2'h1
            && bit_sel == prev_insn[9:7]
            ##1 file_addr == $past(prev_insn[6:0]);
    endproperty
    a_bit_fields: assert property (p_bit_fields)
        else $error("bit-oriented fields decoded wrongly");
    property p_lit_fmt;
        fetch_req && prev_insn[13:12] == 2'h2 |-> fmt == 2'h2;
    endproperty
    a_lit_fmt: assert property (p_lit_fmt)
        else $error("control word not classed as literal");
    property p_ptr;
        fetch_req |-> ptr_sel == prev_insn[2];
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer index bit decoded wrongly");
    property p_flag_time;
        $changed(carry) || $changed(zero) || $changed(work)
            || $changed(nibble_overflow_flag) |-> q_phase == 2'h0;
    endproperty
    a_flag_time: assert property (p_flag_time)
        else $error("result landed away from the cycle end");
endmodule

bind insn_decode_timing decode_checker decode_checker_i (
    .clk(clk), .rst_n(rst_n), .insn(insn), .file_rdata(file_rdata),
    .ptr0(ptr0), .ptr1(ptr1), .fetch_req(fetch_req), .q_phase(q_phase),
    .fmt(fmt), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .work(work),
    .carry(carry), .nibble_overflow_flag(nibble_overflow_flag),
    .zero(zero), .pc_change(pc_change), .skip_taken(skip_taken),
    .nop_cycle(nop_cycle), .ptr_sel(ptr_sel), .bit_sel(bit_sel)
);

/* dv/file_regs_model.sv */
// file register model on the far side of the decoder's file port
// assumes: one write strobe per clock, data valid with the strobe
`timescale 1ns/1ps

module file_regs_model (
    input  wire       clk,
    input  wire [6:0] file_addr,
    input  wire       file_rd,
    input  wire       file_wr,
    input  wire [7:0] file_wdata,
    output wire [7:0] file_rdata,
    output int        rd_cnt
);
    logic [7:0] regs [0:127];

    initial rd_cnt = 0;
    // outside the strobe the data is wrong, so a late sample fails
    assign file_rdata = file_rd ? regs[file_addr] : ~regs[file_addr];
    // count reads and store written results
    always @(posedge clk) begin
        if (file_rd)
            rd_cnt <= rd_cnt + 1;
        if (file_wr)
            regs[file_addr] <= file_wdata;
    end
endmodule

/* dv/testbench.sv */
// self-checking bench for the decode and cycle-timing block
// assumes: design, checker and file register model compile alongside
`timescale 1ns/1ps

module testbench;
    reg         clk;
    reg         rst_n;
    reg  [13:0] insn;
    reg  [15:0] ptr0;
    reg  [15:0] ptr1;
    wire [7:0]  file_rdata;
    wire        fetch_req;
    wire [1:0]  q_phase;
    wire [1:0]  fmt;
    wire [6:0]  file_addr;
    wire        file_rd;
    wire        file_wr;
    wire [7:0]  file_wdata;
    wire [7:0]  work;
    wire        carry;
    wire        nibble_overflow_flag;
    wire        zero;
    wire        pc_change;
    wire        skip_taken;
    wire        nop_cycle;
    wire        ptr_sel;
    wire [2:0]  bit_sel;
    int         rd_cnt;
    int         mismatches;
    int         checks;
    reg  [1:0]  cap_fmt;
    reg  [6:0]  cap_addr;
    reg  [2:0]  cap_bit;
    reg         cap_ptr;

    insn_decode_timing insn_decode_timing_i (
        .clk(clk), .rst_n(rst_n), .insn(insn), .file_rdata(file_rdata),
        .ptr0(ptr0), .ptr1(ptr1), .fetch_req(fetch_req), .q_phase(q_phase),
        .fmt(fmt), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata), .work(work),
        .carry(carry), .nibble_overflow_flag(nibble_overflow_flag),
        .zero(zero), .pc_change(pc_change), .skip_taken(skip_taken),
        .nop_cycle(nop_cycle), .ptr_sel(ptr_sel), .bit_sel(bit_sel));
    file_regs_model file_regs_model_i (
        .clk(clk), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata),
        .file_rdata(file_rdata), .rd_cnt(rd_cnt));

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task chk(input string name, input logic [15:0] e, input logic [15:0] g);
        begin
            checks++;
            if (g !== e) begin
                mismatches++;
                $display("BAD %s exp %h got %h", name, e, g);
            end
        end
    endtask

    // clocks to the next fetch pulse; a hang ends the run
    task wait_fetch(output int k);
        begin
            k = 1;
            @(negedge clk);
            while (fetch_req !== 1'b1) begin
                if (k > 40) begin
                    chk("fetch", 16'h0001, 16'h0000);
                    print_verdict;
                end
                @(negedge clk);
                k++;
            end
        end
    endtask

    // present one word, capture its fields, return its clock count
    task run(input [13:0] w, output int n);
        int k;
        begin
            wait_fetch(k);
            insn = w;
            wait_fetch(k);
            insn = 14'h0000; // word now latched; a no-op follows it
            cap_fmt = fmt;
            cap_bit = bit_sel;
            cap_ptr = ptr_sel;
            @(negedge clk);
            cap_addr = file_addr; // address register trails the latch
            wait_fetch(n);
            n = n + 1;
            @(negedge clk); // let the result's file write land
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // each byte op but the two skip ops once, add twice: result place, flags, one read, one cycle
    task t_alu;
        reg [13:0] w [0:9];
        reg [7:0]  v [0:9];
        reg [2:0]  f [0:9];
        int        n;
        int        r;
        int        i;
        begin
            w = '{14'h0710, 14'h0791, 14'h3d11, 14'h0512, 14'h0493,
                  14'h3594, 14'h3615, 14'h3796, 14'h0d97, 14'h0c98};
            v = '{8'h8f, 8'h10, 8'ha0, 8'h00, 8'h01,
                  8'h02, 8'h00, 8'hc0, 8'h00, 8'h81};
            f = '{3'h0, 3'h6, 3'h2, 3'h3, 3'h2,
                  3'h6, 3'h7, 3'h2, 3'h6, 3'h2};
            for (i = 0; i < 10; i++) begin
                r = rd_cnt;
                run(w[i], n);
                chk("cycles", 16'h0004, n);
                chk("reads", r + 1, rd_cnt);
                chk("fmt", 16'h0000, cap_fmt);
                chk("addr", w[i][6:0], cap_addr);
                if (w[i][7])
                    chk("file", v[i], file_regs_model_i.regs[w[i][6:0]]);
                else
                    chk("work", v[i], work);
                chk("flags", f[i], {carry, nibble_overflow_flag, zero});
            end
        end
    endtask

    // cycle counts of control, skip, indirect and undefined words
    task t_timing;
        reg [13:0] w [0:18];
        int        c [0:18];
        int        n;
        int        i;
        begin
            w = '{14'h000a, 14'h0008, 14'h0009, 14'h000b, 14'h3455,
                  14'h3223, 14'h2123, 14'h2923, 14'h3e55, 14'h0000,
                  14'h1820, 14'h18a0, 14'h1c20, 14'h1ca0, 14'h0ba1,
                  14'h0ba1, 14'h0fa2, 14'h0700, 14'h0701};
            c = '{2, 2, 2, 2, 2, 2, 2, 2, 1, 1, 1, 2, 2, 1, 2, 1, 2, 2, 1};
            for (i = 0; i < 19; i++) begin
                run(w[i], n);
                chk("timing", c[i] * 4, n);
            end
        end
    endtask

    // field split of a bit-oriented and a literal word
    task t_fields;
        int n;
        begin
            run(14'h1ea5, n);
            chk("bfmt", 16'h0001, cap_fmt);
            chk("baddr", 16'h0025, cap_addr);
            chk("bit", 16'h0005, cap_bit);
            chk("ptr", 16'h0001, cap_ptr);
            run(14'h3455, n);
            chk("lfmt", 16'h0002, cap_fmt);
        end
    endtask

    // reset in mid-run, then timing resumes from phase zero
    task t_rereset;
        int n;
        begin
            @(negedge clk);
            rst_n = 1'b0;
            @(negedge clk);
            chk("rnop", 16'h0001, nop_cycle);
            chk("rwork", 16'h0000, work);
            rst_n = 1'b1;
            run(14'h0000, n);
            chk("rcyc", 16'h0004, n);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        insn = 14'h0000;
        ptr0 = 16'h8000; // pointer zero aims into program memory
        ptr1 = 16'h0000;
        mismatches = 0;
        checks = 0;
        repeat (20) @(negedge clk);
        chk("nop", 16'h0001, nop_cycle);
        chk("fetch0", 16'h0000, fetch_req);
        file_regs_model_i.regs[7'h00] = 8'h00;
        file_regs_model_i.regs[7'h01] = 8'h00;
        file_regs_model_i.regs[7'h10] = 8'h8f;
        file_regs_model_i.regs[7'h11] = 8'h81;
        file_regs_model_i.regs[7'h12] = 8'h00;
        file_regs_model_i.regs[7'h13] = 8'h01;
        file_regs_model_i.regs[7'h14] = 8'h81;
        file_regs_model_i.regs[7'h15] = 8'h01;
        file_regs_model_i.regs[7'h16] = 8'h80;
        file_regs_model_i.regs[7'h17] = 8'h80;
        file_regs_model_i.regs[7'h18] = 8'h02;
        file_regs_model_i.regs[7'h20] = 8'h01;
        file_regs_model_i.regs[7'h21] = 8'h01;
        file_regs_model_i.regs[7'h22] = 8'hff;
        file_regs_model_i.regs[7'h25] = 8'h00;
        rst_n = 1'b1;
        t_alu;
        t_timing;
        t_fields;
        t_rereset;
        print_verdict;
    end
endmodule
